// File: hw/io_port_params.svh
/*
  Register indices, bit positions, reset values and bus answers for the
  eight-bit I/O port block. Included by its bare name; definitions only.
*/
`ifndef IO_PORT_PARAMS_SVH
`define IO_PORT_PARAMS_SVH

// register indices; byte address is four times the index
`define REG_PE_PIN_IDX 4'h1
`define REG_PE_DIR_IDX 4'h2
`define REG_PE_LAT_IDX 4'h3
`define REG_PB_PIN_IDX 4'h4
`define REG_PB_DIR_IDX 4'h5
`define REG_PB_LAT_IDX 4'h6

`define PORT_RESET_VAL 8'h00

// port b alternate function bit positions
`define PB_TIMER0_BIT 4
`define PB_MISO_BIT 3
`define PB_MOSI_BIT 2
`define PB_SCK_BIT 1
`define PB_SS_BIT 0

`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

// File: hw/io_port_pkg.sv
/*
  Types shared by the I/O port block: bus response state and port byte.
  Assumes nothing of its surroundings.
*/
package io_port_pkg;
  typedef logic [7:0] port_byte_t;
  typedef enum logic [1:0] {
    RSP_IDLE = 2'b01,
    RSP_BUSY = 2'b10
  } rsp_state_t;
endpackage : io_port_pkg

// File: hw/io_sync8.sv
/*
  Two-flop synchroniser for eight pin inputs.
  Assumes pins may change at any time relative to mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module io_sync8 (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] din,
  output logic [7:0] dout
);
  logic [7:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      meta_q <= 8'h00;
      dout <= 8'h00;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule : io_sync8
`default_nettype wire

// File: hw/io_pin_cell.sv
/*
  One port pin: direction, output level and pull-up, with optional
  forced-input and alternate output value. Outputs registered.
  Assumes the caller gates output enable with reset where needed.
*/
`timescale 1ns/1ps
`default_nettype none
module io_pin_cell (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic dir,
  input wire logic latch,
  input wire logic force_in,
  input wire logic alt_en,
  input wire logic alt_val,
  output logic pin_out,
  output logic pin_oe,
  output logic pin_pullup
);
  logic oe_d;

  always_comb begin
    oe_d = dir & ~force_in;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pin_oe <= 1'b0;
      pin_out <= 1'b0;
      pin_pullup <= 1'b0;
    end else begin
      pin_oe <= oe_d;
      // push-pull level is the latch unless a peripheral owns the pin
      pin_out <= alt_en ? alt_val : latch;
      // forced inputs keep latch-selected pull-up
      pin_pullup <= ~oe_d & latch;
    end
  end
endmodule : io_pin_cell
`default_nettype wire

// File: hw/io_port_spi_pin_override.sv
/*
  Eight-bit port E with a port B carrying SPI and timer overrides,
  registers over AXI4-Lite. Assumes synchronous pin buffers outside
  resolve out/oe/pullup, and SPI and timer cores drive the mode inputs.
*/
`timescale 1ns/1ps
`default_nettype none
`include "io_port_params.svh"
module io_port_spi_pin_override (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [5:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [5:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire logic [7:0] port_e_output_latch_in,
  output logic [7:0] port_e_output_latch_out,
  output logic [7:0] port_e_output_latch_oe,
  output logic [7:0] port_e_output_latch_pullup,
  input wire logic [7:0] portb_in,
  output logic [7:0] portb_out,
  output logic [7:0] portb_oe,
  output logic [7:0] portb_pullup,
  output logic [7:0] portb_sync,
  input wire logic spi_enable,
  input wire logic spi_master,
  input wire logic spi_miso_out,
  input wire logic spi_mosi_out,
  input wire logic spi_sck_out,
  input wire logic timer0_out_en,
  input wire logic timer0_compare_out,
  output logic spi_slave_active
);
  io_port_pkg::port_byte_t pe_dir_q;
  io_port_pkg::port_byte_t pe_lat_q;
  io_port_pkg::port_byte_t pb_dir_q;
  io_port_pkg::port_byte_t pb_lat_q;
  io_port_pkg::port_byte_t pe_sync;
  io_port_pkg::port_byte_t pe_oe_q;
  io_port_pkg::port_byte_t pb_oe_q;
  io_port_pkg::port_byte_t pb_force;
  io_port_pkg::port_byte_t pb_alt_en;
  io_port_pkg::port_byte_t pb_alt_val;
  io_port_pkg::rsp_state_t wr_state_q;
  logic aw_got_q;
  logic w_got_q;
  logic [3:0] aw_idx_q;
  logic [7:0] wdata_q;
  logic wstrb0_q;
  logic aw_take;
  logic w_take;
  logic aw_have;
  logic w_have;
  logic do_wr;
  logic [3:0] wr_idx;
  logic [7:0] wr_byte;
  logic wr_lane;
  logic wr_mapped;
  logic ar_take;
  logic [3:0] rd_idx;
  logic spi_slave;
  logic spi_mst;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  io_sync8 u_sync_e (
    .mclk(mclk),
    .rst_n(rst_n),
    .din(port_e_output_latch_in),
    .dout(pe_sync)
  );

  io_sync8 u_sync_b (
    .mclk(mclk),
    .rst_n(rst_n),
    .din(portb_in),
    .dout(portb_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // port b overrides

  always_comb begin
    spi_slave = spi_enable & ~spi_master;
    spi_mst = spi_enable & spi_master;
    pb_force = 8'h00;
    pb_alt_en = 8'h00;
    pb_alt_val = 8'h00;
    pb_force[`PB_MISO_BIT] = spi_mst;
    pb_force[`PB_MOSI_BIT] = spi_slave;
    pb_force[`PB_SCK_BIT] = spi_slave;
    pb_force[`PB_SS_BIT] = spi_slave;
    // timer drives level only; direction bit still gates the pin
    pb_alt_en[`PB_TIMER0_BIT] = timer0_out_en;
    pb_alt_val[`PB_TIMER0_BIT] = timer0_compare_out;
    pb_alt_en[`PB_MISO_BIT] = spi_slave;
    pb_alt_val[`PB_MISO_BIT] = spi_miso_out;
    pb_alt_en[`PB_MOSI_BIT] = spi_mst;
    pb_alt_val[`PB_MOSI_BIT] = spi_mosi_out;
    pb_alt_en[`PB_SCK_BIT] = spi_mst;
    pb_alt_val[`PB_SCK_BIT] = spi_sck_out;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      spi_slave_active <= 1'b0;
    end else begin
      spi_slave_active <= spi_slave & ~portb_sync[`PB_SS_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin cells

  for (genvar i = 0; i < 8; i++) begin : g_pin
    io_pin_cell u_e (
      .mclk(mclk),
      .rst_n(rst_n),
      .dir(pe_dir_q[i]),
      .latch(pe_lat_q[i]),
      .force_in(1'b0),
      .alt_en(1'b0),
      .alt_val(1'b0),
      .pin_out(port_e_output_latch_out[i]),
      .pin_oe(pe_oe_q[i]),
      .pin_pullup(port_e_output_latch_pullup[i])
    );
    io_pin_cell u_b (
      .mclk(mclk),
      .rst_n(rst_n),
      .dir(pb_dir_q[i]),
      .latch(pb_lat_q[i]),
      .force_in(pb_force[i]),
      .alt_en(pb_alt_en[i]),
      .alt_val(pb_alt_val[i]),
      .pin_out(portb_out[i]),
      .pin_oe(pb_oe_q[i]),
      .pin_pullup(portb_pullup[i])
    );
  end

  // reset must release the pins even with mclk stopped, hence the gate
  assign port_e_output_latch_oe = pe_oe_q & {8{rst_n}};
  assign portb_oe = pb_oe_q & {8{rst_n}};

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write path

  always_comb begin
    aw_take = s_awvalid & s_awready;
    w_take = s_wvalid & s_wready;
    aw_have = aw_got_q | aw_take;
    w_have = w_got_q | w_take;
    do_wr = aw_have & w_have & (wr_state_q == io_port_pkg::RSP_IDLE);
    wr_idx = aw_got_q ? aw_idx_q : s_awaddr[5:2];
    wr_byte = w_got_q ? wdata_q : s_wdata[7:0];
    wr_lane = w_got_q ? wstrb0_q : s_wstrb[0];
    unique case (wr_idx)
      `REG_PE_PIN_IDX,
      `REG_PE_DIR_IDX,
      `REG_PE_LAT_IDX,
      `REG_PB_PIN_IDX,
      `REG_PB_DIR_IDX,
      `REG_PB_LAT_IDX: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_idx_q <= 4'h0;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
    end else begin
      aw_got_q <= aw_have & ~do_wr;
      w_got_q <= w_have & ~do_wr;
      if (aw_take) begin
        aw_idx_q <= s_awaddr[5:2];
      end
      if (w_take) begin
        wdata_q <= s_wdata[7:0];
        wstrb0_q <= s_wstrb[0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_state_q <= io_port_pkg::RSP_IDLE;
      s_bvalid <= 1'b0;
      s_bresp <= `AXI_RESP_OKAY;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
    end else begin
      unique case (wr_state_q)
        io_port_pkg::RSP_IDLE: begin
          s_awready <= ~aw_have;
          s_wready <= ~w_have;
          if (do_wr) begin
            wr_state_q <= io_port_pkg::RSP_BUSY;
            s_bvalid <= 1'b1;
            s_bresp <= wr_mapped ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
            s_awready <= 1'b0;
            s_wready <= 1'b0;
          end
        end
        io_port_pkg::RSP_BUSY: begin
          if (s_bready) begin
            wr_state_q <= io_port_pkg::RSP_IDLE;
            s_bvalid <= 1'b0;
            s_awready <= 1'b1;
            s_wready <= 1'b1;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port registers

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pe_dir_q <= `PORT_RESET_VAL;
      pe_lat_q <= `PORT_RESET_VAL;
      pb_dir_q <= `PORT_RESET_VAL;
      pb_lat_q <= `PORT_RESET_VAL;
    end else if (do_wr && wr_lane) begin
      // pin-input indices fall through: no storage behind them
      if (wr_idx == `REG_PE_DIR_IDX) begin
        pe_dir_q <= wr_byte;
      end
      if (wr_idx == `REG_PE_LAT_IDX) begin
        pe_lat_q <= wr_byte;
      end
      if (wr_idx == `REG_PB_DIR_IDX) begin
        pb_dir_q <= wr_byte;
      end
      if (wr_idx == `REG_PB_LAT_IDX) begin
        pb_lat_q <= wr_byte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read path

  always_comb begin
    ar_take = s_arvalid & s_arready;
    rd_idx = s_araddr[5:2];
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= `AXI_RESP_OKAY;
    end else if (s_rvalid) begin
      if (s_rready) begin
        s_rvalid <= 1'b0;
        s_arready <= 1'b1;
      end
    end else if (ar_take) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b1;
      s_rresp <= `AXI_RESP_OKAY;
      s_rdata <= 32'h0000_0000;
      unique case (rd_idx)
        `REG_PE_PIN_IDX: s_rdata[7:0] <= pe_sync;
        `REG_PE_DIR_IDX: s_rdata[7:0] <= pe_dir_q;
        `REG_PE_LAT_IDX: s_rdata[7:0] <= pe_lat_q;
        `REG_PB_PIN_IDX: s_rdata[7:0] <= portb_sync;
        `REG_PB_DIR_IDX: s_rdata[7:0] <= pb_dir_q;
        `REG_PB_LAT_IDX: s_rdata[7:0] <= pb_lat_q;
        default: s_rresp <= `AXI_RESP_SLVERR;
      endcase
    end else begin
      s_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  a_timer_dir: assert property (@(posedge mclk) disable iff (!rst_n)
    !pb_dir_q[`PB_TIMER0_BIT] |=> !portb_oe[`PB_TIMER0_BIT])
    else $error("timer pin driven without direction bit");

  a_miso_forced: assert property (@(posedge mclk) disable iff (!rst_n)
    (spi_mst || (spi_slave && !pb_dir_q[`PB_MISO_BIT])) |=> !portb_oe[`PB_MISO_BIT])
    else $error("miso driven while it must be input");

  a_mosi_forced: assert property (@(posedge mclk) disable iff (!rst_n)
    spi_slave |=> !portb_oe[`PB_MOSI_BIT])
    else $error("mosi driven in slave mode");

  a_sck_master: assert property (@(posedge mclk) disable iff (!rst_n)
    (spi_mst && pb_dir_q[`PB_SCK_BIT]) |=> portb_oe[`PB_SCK_BIT] ##0 (portb_out[`PB_SCK_BIT] == $past(spi_sck_out)))
    else $error("sck not driven by master");

  a_ss_forced: assert property (@(posedge mclk) disable iff (!rst_n)
    spi_slave ##1 spi_slave |-> !portb_oe[`PB_SS_BIT] && !portb_oe[`PB_SCK_BIT])
    else $error("ss or sck driven in slave mode");

  // an edge taken under reset clears the flops, so only edges with reset released are checked
  a_slave_active: assert property (@(posedge mclk) disable iff (!rst_n)
    rst_n |=> spi_slave_active == ($past(spi_slave) && !$past(portb_sync[`PB_SS_BIT])))
    else $error("slave active does not follow ss");

  a_sync_delay: assert property (@(posedge mclk) disable iff (!rst_n)
    rst_n ##1 rst_n |=> pe_sync == $past(port_e_output_latch_in, 2))
    else $error("pin synchroniser not two stages");

  a_pin_read: assert property (@(posedge mclk) disable iff (!rst_n)
    (ar_take && rd_idx == `REG_PE_PIN_IDX) |=> s_rvalid && s_rdata == {24'h000000, $past(pe_sync)})
    else $error("pin read does not show live pins");

  a_dir_oe: assert property (@(posedge mclk) disable iff (!rst_n)
    ##1 port_e_output_latch_oe == $past(pe_dir_q))
    else $error("port e output enable differs from direction");

  a_pullup: assert property (@(posedge mclk) disable iff (!rst_n)
    ##1 port_e_output_latch_pullup == $past(~pe_dir_q & pe_lat_q))
    else $error("port e pull-up wrong");

  a_out_level: assert property (@(posedge mclk) disable iff (!rst_n)
    ##1 port_e_output_latch_out == $past(pe_lat_q))
    else $error("port e output level differs from latch");

  a_reset_tri: assert property (@(posedge mclk)
    !rst_n |-> port_e_output_latch_oe == 8'h00 && portb_oe == 8'h00)
    else $error("pins driven during reset");

  a_pin_ro: assert property (@(posedge mclk) disable iff (!rst_n)
    (do_wr && wr_idx == `REG_PE_PIN_IDX) |=> $stable(pe_dir_q) && $stable(pe_lat_q))
    else $error("write to pin address changed state");

  c_write: cover property (@(posedge mclk) disable iff (!rst_n)
    do_wr && wr_idx == `REG_PE_DIR_IDX ##1 s_bvalid);
  c_pin_read: cover property (@(posedge mclk) disable iff (!rst_n)
    ar_take && rd_idx == `REG_PE_PIN_IDX);
  c_slave_on: cover property (@(posedge mclk) disable iff (!rst_n)
    $rose(spi_slave_active));
  c_master_miso: cover property (@(posedge mclk) disable iff (!rst_n)
    spi_mst && pb_dir_q[`PB_MISO_BIT]);
endmodule : io_port_spi_pin_override
`default_nettype wire

// File: test/pin_partner.sv
/*
  Far side of the port block: the sixteen pins with their external drivers.
  Assumes the bench sets which pins an outside source drives and to what level.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  input wire logic mclk,
  input wire logic [7:0] e_out,
  input wire logic [7:0] e_oe,
  input wire logic [7:0] e_pu,
  input wire logic [7:0] e_ext_en,
  input wire logic [7:0] e_ext_val,
  input wire logic [7:0] b_out,
  input wire logic [7:0] b_oe,
  input wire logic [7:0] b_pu,
  input wire logic [7:0] b_ext_en,
  input wire logic [7:0] b_ext_val,
  output logic [7:0] e_pin,
  output logic [7:0] b_pin
);
  logic [7:0] float_q;

  ////////////////////////////////////////////////////////////////////////////
  // a floating line toggles each cycle so no stale level can pass for a read
  initial float_q = 8'h55;
  always @(posedge mclk) float_q <= ~float_q;

  function automatic logic [7:0] level(input logic [7:0] oe, input logic [7:0] o, input logic [7:0] pu,
                                       input logic [7:0] en, input logic [7:0] v, input logic [7:0] fl);
    return (oe & o) | (~oe & en & v) | (~oe & ~en & pu) | (~oe & ~en & ~pu & fl);
  endfunction : level

  ////////////////////////////////////////////////////////////////////////////
  assign e_pin = level(e_oe, e_out, e_pu, e_ext_en, e_ext_val, float_q);
  assign b_pin = level(b_oe, b_out, b_pu, b_ext_en, b_ext_val, float_q);
endmodule : pin_partner
`default_nettype wire

// File: test/io_port_spi_pin_override_tb.sv
/*
  Self-checking bench for the port block: register rows, pin levels, spi overrides, reset.
  Assumes pin_partner resolves the pins and the bench plays the spi and timer cores.
*/
`timescale 1ns/1ps
`default_nettype none
`include "io_port_params.svh"
module io_port_spi_pin_override_tb;
  typedef struct {
    logic [3:0] widx;
    logic [7:0] wd;
    logic [1:0] bexp;
    logic [3:0] ridx;
    logic [7:0] rexp;
    logic [1:0] rrexp;
  } row_t;
  logic mclk = 1'h0;
  logic rst_n = 1'h0;
  logic [5:0] s_awaddr = 6'h00, s_araddr = 6'h00;
  logic s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0, s_arvalid = 1'h0, s_rready = 1'h0;
  logic [31:0] s_wdata = 32'h0;
  logic [3:0] s_wstrb = 4'h0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, spi_slave_active;
  logic [1:0] s_bresp, s_rresp;
  logic [31:0] s_rdata, rd;
  logic [1:0] rsp, rrsp;
  logic [7:0] port_e_output_latch_in, port_e_output_latch_out, port_e_output_latch_oe, port_e_output_latch_pullup, portb_in, portb_out, portb_oe, portb_pullup, portb_sync;
  logic spi_enable = 1'h0, spi_master = 1'h0, spi_miso_out = 1'h0, spi_mosi_out = 1'h0, spi_sck_out = 1'h0;
  logic timer0_out_en = 1'h0, timer0_compare_out = 1'h0;
  logic [7:0] e_ext_en = 8'h5A, e_ext_val = 8'h0F, b_ext_en = 8'hFF, b_ext_val = 8'h0F;
  int err_count = 0, n_tests = 0, cycles = 0;
  row_t rows [5] = '{
    '{`REG_PE_DIR_IDX, 8'hA5, `AXI_RESP_OKAY, `REG_PE_DIR_IDX, 8'hA5, `AXI_RESP_OKAY},
    '{`REG_PE_LAT_IDX, 8'h3C, `AXI_RESP_OKAY, `REG_PE_LAT_IDX, 8'h3C, `AXI_RESP_OKAY},
    '{`REG_PE_PIN_IDX, 8'hFF, `AXI_RESP_OKAY, `REG_PE_LAT_IDX, 8'h3C, `AXI_RESP_OKAY},
    '{4'hF, 8'h77, `AXI_RESP_SLVERR, 4'hF, 8'h00, `AXI_RESP_SLVERR},
    '{`REG_PB_PIN_IDX, 8'hFF, `AXI_RESP_OKAY, `REG_PB_LAT_IDX, 8'h00, `AXI_RESP_OKAY}};

  io_port_spi_pin_override io_port_spi_pin_override_i (.mclk(mclk), .rst_n(rst_n), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
    .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .port_e_output_latch_in(port_e_output_latch_in), .port_e_output_latch_out(port_e_output_latch_out), .port_e_output_latch_oe(port_e_output_latch_oe),
    .port_e_output_latch_pullup(port_e_output_latch_pullup), .portb_in(portb_in), .portb_out(portb_out), .portb_oe(portb_oe),
    .portb_pullup(portb_pullup), .portb_sync(portb_sync), .spi_enable(spi_enable), .spi_master(spi_master),
    .spi_miso_out(spi_miso_out), .spi_mosi_out(spi_mosi_out), .spi_sck_out(spi_sck_out),
    .timer0_out_en(timer0_out_en), .timer0_compare_out(timer0_compare_out), .spi_slave_active(spi_slave_active));

  pin_partner pin_partner_i (.mclk(mclk), .e_out(port_e_output_latch_out), .e_oe(port_e_output_latch_oe), .e_pu(port_e_output_latch_pullup),
    .e_ext_en(e_ext_en), .e_ext_val(e_ext_val), .b_out(portb_out), .b_oe(portb_oe), .b_pu(portb_pullup),
    .b_ext_en(b_ext_en), .b_ext_val(b_ext_val), .e_pin(port_e_output_latch_in), .b_pin(portb_in));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #20 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    // generous ceiling: the whole run needs under a hundred cycles
    if (cycles == 5000) begin
      err_count++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic axi_write(input logic [3:0] idx, input logic [7:0] d, output logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 1'h0;
    w_done = 1'h0;
    s_awaddr <= {idx, 2'h0};
    s_awvalid <= 1'h1;
    s_wdata <= {24'h0, d};
    s_wstrb <= 4'hF;
    s_wvalid <= 1'h1;
    while (!(aw_done && w_done)) begin
      @(posedge mclk);
      if (!aw_done && s_awready === 1'h1) begin
        aw_done = 1'h1;
        s_awvalid <= 1'h0;
      end
      if (!w_done && s_wready === 1'h1) begin
        w_done = 1'h1;
        s_wvalid <= 1'h0;
      end
    end
    s_bready <= 1'h1;
    do @(posedge mclk); while (s_bvalid !== 1'h1);
    r = s_bresp;
    s_bready <= 1'h0;
  endtask : axi_write

  task automatic axi_read(input logic [3:0] idx, output logic [31:0] d, output logic [1:0] r);
    s_araddr <= {idx, 2'h0};
    s_arvalid <= 1'h1;
    do @(posedge mclk); while (s_arready !== 1'h1);
    s_arvalid <= 1'h0;
    s_rready <= 1'h1;
    do @(posedge mclk); while (s_rvalid !== 1'h1);
    d = s_rdata;
    r = s_rresp;
    s_rready <= 1'h0;
  endtask : axi_read

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'h1;
    @(posedge mclk);
    foreach (rows[i]) begin
      axi_write(rows[i].widx, rows[i].wd, rsp);
      chk("bresp", rows[i].bexp, rsp);
      axi_read(rows[i].ridx, rd, rrsp);
      chk("rdata", rows[i].rexp, rd);
      chk("rresp", rows[i].rrexp, rrsp);
    end
    repeat (3) @(posedge mclk);
    chk("port_e_output_latch_oe", 8'hA5, port_e_output_latch_oe);
    chk("port_e_output_latch_out", 8'h24, port_e_output_latch_out & port_e_output_latch_oe);
    chk("port_e_output_latch_pullup", 8'h18, port_e_output_latch_pullup);
    axi_read(`REG_PE_PIN_IDX, rd, rrsp);
    chk("port e pins", 32'h2E, rd);
    // port b pins are all inputs here; two flops must hide a change for two edges
    b_ext_val <= 8'hF0;
    repeat (2) @(posedge mclk);
    chk("portb_sync early", 8'h0F, portb_sync);
    @(posedge mclk);
    chk("portb_sync late", 8'hF0, portb_sync);
    axi_write(`REG_PB_DIR_IDX, 8'h1F, rsp);
    axi_write(`REG_PB_LAT_IDX, 8'h0F, rsp);
    b_ext_en <= 8'hE8;
    spi_enable <= 1'h1;
    spi_master <= 1'h1;
    timer0_out_en <= 1'h1;
    timer0_compare_out <= 1'h1;
    spi_sck_out <= 1'h1;
    spi_miso_out <= 1'h1;
    repeat (3) @(posedge mclk);
    chk("master oe", 8'h17, portb_oe);
    chk("master out", 8'h13, portb_out & portb_oe);
    chk("master pullup", 8'h08, portb_pullup);
    chk("master active", 1'h0, spi_slave_active);
    spi_master <= 1'h0;
    // miso level now differs from its latch bit, so the slave routing shows
    spi_miso_out <= 1'h0;
    b_ext_en <= 8'hE7;
    b_ext_val <= 8'h00;
    repeat (5) @(posedge mclk);
    chk("slave oe", 8'h18, portb_oe);
    chk("slave out", 8'h10, portb_out & portb_oe);
    chk("slave pullup", 8'h07, portb_pullup);
    chk("slave active", 1'h1, spi_slave_active);
    b_ext_val <= 8'h01;
    repeat (5) @(posedge mclk);
    chk("slave idle", 1'h0, spi_slave_active);
    axi_write(`REG_PB_DIR_IDX, 8'h0F, rsp);
    repeat (3) @(posedge mclk);
    chk("timer pin off", 8'h08, portb_oe);
    // mid-run reset must release the pins before any clock edge arrives
    rst_n <= 1'h0;
    #1;
    chk("port_e_output_latch_oe reset", 8'h00, port_e_output_latch_oe);
    chk("portb_oe reset", 8'h00, portb_oe);
    repeat (2) @(posedge mclk);
    rst_n <= 1'h1;
    @(posedge mclk);
    axi_read(`REG_PE_DIR_IDX, rd, rrsp);
    chk("dir after reset", 32'h0, rd);
    axi_read(`REG_PE_LAT_IDX, rd, rrsp);
    chk("latch after reset", 32'h0, rd);
    give_verdict();
  end
endmodule : io_port_spi_pin_override_tb
`default_nettype wire
